// ---- uid_pkg.sv ----
// Constants for the unique identifier fuse reader.
// Assumes a single 25 MHz clock and a fuse array that answers serially.
package uid_pkg;
  localparam int UID_WIDTH = 64;
  localparam int UID_CLK_MAX_MHZ = 100;
  localparam int UID_CLK_MHZ = 25;
  localparam logic [63:0] UID_ID_RESET = 64'h0000_0000_0000_0000;
  localparam logic UID_READY_RESET = 1'b0;
  // Cycles the strobe register and two-flop synchroniser add before a bit reaches the collector
  localparam int UID_FUSE_LAT = 3;

  typedef enum logic [2:0] {
    UID_IDLE = 3'b001,
    UID_FETCH = 3'b010,
    UID_DONE = 3'b100
  } uid_state_t;
endpackage : uid_pkg

// ---- uid_fuse_reader.sv ----
// Unique identifier fuse reader: shifts the fuse word in serially, then holds it.
// Assumes fuse data is stable (one bit per shift) and synchronised here anyway.
`timescale 1ns/1ps
module uid_fuse_reader #(
  parameter int WIDTH = uid_pkg::UID_WIDTH
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  input wire logic RESET,
  // Fuse array side
  input wire logic FUSE_BIT,
  output logic FUSE_SHIFT,
  // User side
  output logic DATA_VALID,
  output logic [WIDTH-1:0] UNIQUE_IDENTIFIER_OUT
);
  // Counter must also reach the load point past the last bit
  localparam int LOAD_AT = WIDTH + uid_pkg::UID_FUSE_LAT;
  localparam int CW = $clog2(LOAD_AT + 2);

  // Shift path needs two bits at least; reset constant is 64 wide
  if (WIDTH < 2 || WIDTH > 64)
  begin : g_bad_width
    $error("WIDTH must be 2..64");
  end
  if (uid_pkg::UID_CLK_MHZ > uid_pkg::UID_CLK_MAX_MHZ)
  begin : g_bad_clock
    $error("Clock above supported rate");
  end

  uid_pkg::uid_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic [WIDTH-1:0] shift_q;
  logic fuse_s1_q;
  logic fuse_s2_q;
  logic rst_s1_q;
  logic rst_s2_q;
  logic [CW-1:0] shift_seen_q;

  // Pins cross in through two flops
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      fuse_s1_q <= 1'b0;
      fuse_s2_q <= 1'b0;
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      fuse_s1_q <= FUSE_BIT;
      fuse_s2_q <= fuse_s1_q;
      rst_s1_q <= RESET;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Sequencer; reset restarts the fetch from idle
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_q <= uid_pkg::UID_IDLE;
      cnt_q <= '0;
    end
    else if (rst_s2_q)
    begin
      state_q <= uid_pkg::UID_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      unique case (state_q)
        uid_pkg::UID_IDLE:
        begin
          state_q <= uid_pkg::UID_FETCH;
          cnt_q <= '0;
        end
        uid_pkg::UID_FETCH:
        begin
          // Strobe register and synchroniser delay each bit by three cycles
          if (cnt_q == CW'(LOAD_AT))
            state_q <= uid_pkg::UID_DONE;
          cnt_q <= cnt_q + CW'(1);
        end
        uid_pkg::UID_DONE:
          state_q <= uid_pkg::UID_DONE;
        default:
          state_q <= uid_pkg::UID_IDLE;
      endcase
    end
  end

  // Shift strobe for the first WIDTH-1 fetch cycles; the first bit needs none
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      FUSE_SHIFT <= 1'b0;
    else
      FUSE_SHIFT <= !rst_s2_q && (state_q == uid_pkg::UID_FETCH) && (cnt_q < CW'(WIDTH - 1));
  end

  // Collect bits, MSB first; sampled three cycles after each shift
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      shift_q <= '0;
    else if (rst_s2_q || state_q == uid_pkg::UID_IDLE)
      shift_q <= '0;
    else if (state_q == uid_pkg::UID_FETCH && cnt_q >= CW'(uid_pkg::UID_FUSE_LAT)
             && cnt_q < CW'(LOAD_AT))
      shift_q <= {shift_q[WIDTH-2:0], fuse_s2_q};
  end

  // Output holds zero until done, then the fetched value
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      UNIQUE_IDENTIFIER_OUT <= uid_pkg::UID_ID_RESET[WIDTH-1:0];
      DATA_VALID <= uid_pkg::UID_READY_RESET;
    end
    else if (rst_s2_q)
    begin
      UNIQUE_IDENTIFIER_OUT <= uid_pkg::UID_ID_RESET[WIDTH-1:0];
      DATA_VALID <= 1'b0;
    end
    else if (state_q == uid_pkg::UID_FETCH && cnt_q == CW'(LOAD_AT))
    begin
      UNIQUE_IDENTIFIER_OUT <= shift_q;
      DATA_VALID <= 1'b1;
    end
  end

  property p_ready_low_in_fetch;
    @(posedge CLK) disable iff (!NRST)
      (state_q != uid_pkg::UID_DONE) |-> !DATA_VALID;
  endproperty
  a_ready_low_in_fetch: assert property (p_ready_low_in_fetch)
    else $error("Ready high before fetch done");

  property p_id_zero_before_ready;
    @(posedge CLK) disable iff (!NRST)
      !DATA_VALID |-> (UNIQUE_IDENTIFIER_OUT == '0);
  endproperty
  a_id_zero_before_ready: assert property (p_id_zero_before_ready)
    else $error("Identifier nonzero before ready");

  property p_id_stable;
    @(posedge CLK) disable iff (!NRST)
      (DATA_VALID && !rst_s2_q) |=> $stable(UNIQUE_IDENTIFIER_OUT);
  endproperty
  a_id_stable: assert property (p_id_stable)
    else $error("Identifier changed while loaded");

  property p_ready_sticky;
    @(posedge CLK) disable iff (!NRST)
      (DATA_VALID && !rst_s2_q) |=> DATA_VALID;
  endproperty
  a_ready_sticky: assert property (p_ready_sticky)
    else $error("Ready dropped without reset");

  property p_reset_clears;
    @(posedge CLK) disable iff (!NRST)
      rst_s2_q |=> (!DATA_VALID && state_q == uid_pkg::UID_IDLE);
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("Reset did not return to idle");

  property p_fetch_completes;
    @(posedge CLK) disable iff (!NRST || rst_s2_q)
      (state_q == uid_pkg::UID_IDLE && !rst_s2_q) |-> ##[1:80] DATA_VALID;
  endproperty
  a_fetch_completes: assert property (p_fetch_completes)
    else $error("Fetch did not finish in time");

  property p_valid_rise_cause;
    @(posedge CLK) disable iff (!NRST)
      $rose(DATA_VALID) |-> $past(state_q) == uid_pkg::UID_FETCH;
  endproperty
  a_valid_rise_cause: assert property (p_valid_rise_cause)
    else $error("Ready rose outside fetch");

  property p_no_shift_when_done;
    @(posedge CLK) disable iff (!NRST)
      DATA_VALID |-> !FUSE_SHIFT;
  endproperty
  a_no_shift_when_done: assert property (p_no_shift_when_done)
    else $error("Fuse shifted after load");

  // Strobes seen this fetch; one short leaves the last bit unread
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      shift_seen_q <= '0;
    else if (rst_s2_q)
      shift_seen_q <= '0;
    else if (FUSE_SHIFT)
      shift_seen_q <= shift_seen_q + CW'(1);
  end

  property p_strobe_total;
    @(posedge CLK) disable iff (!NRST)
      $rose(DATA_VALID) |-> (shift_seen_q == CW'(WIDTH - 1));
  endproperty
  a_strobe_total: assert property (p_strobe_total)
    else $error("Wrong number of fuse strobes");

  property p_shift_only_in_fetch;
    @(posedge CLK) disable iff (!NRST)
      FUSE_SHIFT |-> ($past(state_q) == uid_pkg::UID_FETCH);
  endproperty
  a_shift_only_in_fetch: assert property (p_shift_only_in_fetch)
    else $error("Fuse strobe outside fetch");

  property p_idle_starts_fetch;
    @(posedge CLK) disable iff (!NRST)
      (state_q == uid_pkg::UID_IDLE && !rst_s2_q) |=> (state_q == uid_pkg::UID_FETCH);
  endproperty
  a_idle_starts_fetch: assert property (p_idle_starts_fetch)
    else $error("Fetch did not start after idle");
endmodule : uid_fuse_reader

// ---- uid_fuse_model.sv ----
// Fuse array model: offers the stored word MSB first, one bit per shift.
// Assumes restart is held until the reader has stopped strobing after reset.
`timescale 1ns/1ps
module uid_fuse_model (
  // Clock and restart
  input wire logic clk,
  input wire logic restart,
  // Fuse side
  input wire logic shift,
  input wire logic [63:0] word,
  output logic fuse_bit
);
  logic [6:0] idx_q;
  logic tgl_q;
  always_ff @(posedge clk)
  begin
    tgl_q <= restart ? 1'b0 : ~tgl_q;
    if (restart)
      idx_q <= 7'h00;
    else if (shift && !idx_q[6])
      idx_q <= idx_q + 7'h01;
  end
  // Past the last bit the line toggles, so a stray sample cannot pass
  assign fuse_bit = idx_q[6] ? tgl_q : word[~idx_q[5:0]];
endmodule : uid_fuse_model

// ---- tb_top.sv ----
// Self-checking bench for the fuse reader with a serial fuse model.
// Assumes a 25 MHz clock; fuse words come from an LFSR seeded at 67.
`timescale 1ns/1ps
module tb_top;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic RESET = 1'b0;
  logic FUSE_BIT, FUSE_SHIFT, DATA_VALID;
  logic [63:0] UNIQUE_IDENTIFIER_OUT;
  logic [63:0] word = 64'h0;
  logic [15:0] lfsr_q = 16'h0043;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int shift_count = 0;
  always #20 CLK = ~CLK;
  uid_fuse_reader DUT (.CLK(CLK), .NRST(NRST), .RESET(RESET), .FUSE_BIT(FUSE_BIT),
    .FUSE_SHIFT(FUSE_SHIFT), .DATA_VALID(DATA_VALID),
    .UNIQUE_IDENTIFIER_OUT(UNIQUE_IDENTIFIER_OUT));
  uid_fuse_model fuse (.clk(CLK), .restart(~NRST | RESET), .shift(FUSE_SHIFT),
    .word(word), .fuse_bit(FUSE_BIT));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // Restart by either reset; the new word is loaded while the model is held.
  // RESET held three edges, NRST six: strobes already past the reset synchroniser are dropped.
  task automatic restart(input logic by_sync);
    if (by_sync)
      RESET = 1'b1;
    else
      NRST = 1'b0;
    repeat (4)
    begin
      lfsr_q = lfsr(lfsr_q);
      word = {word[47:0], lfsr_q};
    end
    repeat (3) @(posedge CLK);
    #1;
    RESET = 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    check("ready cleared", {63'h0, DATA_VALID}, 64'h0);
    check("id cleared", UNIQUE_IDENTIFIER_OUT, 64'h0);
    shift_count = 0;
    NRST = 1'b1;
  endtask : restart
  task automatic fetch_and_check();
    int n;
    n = 0;
    while (DATA_VALID !== 1'b1 && n < 100)
    begin
      check("id before ready", UNIQUE_IDENTIFIER_OUT, 64'h0);
      @(posedge CLK);
      #1;
      n++;
    end
    check("ready after fetch", {62'h0, n > 50, DATA_VALID}, 64'h3);
    check("id", UNIQUE_IDENTIFIER_OUT, word);
    repeat (30)
    begin
      @(posedge CLK);
      #1;
      check("held ready", {63'h0, DATA_VALID}, 64'h1);
      check("held id", UNIQUE_IDENTIFIER_OUT, word);
    end
    check("fuse strobes", shift_count, uid_pkg::UID_WIDTH - 1);
  endtask : fetch_and_check
  always @(posedge CLK)
  begin
    cycles++;
    if (FUSE_SHIFT)
      shift_count++;
    if (cycles == 3000)
    begin
      fail_count++;
      summarize();
    end
  end
  initial
  begin
    for (int i = 0; i < 6; i++)
    begin
      restart(i[0]);
      // Abort mid-fetch; pass 3 by the synchronous reset, others by the pin
      if (lfsr_q[0] || i == 2 || i == 3)
      begin
        repeat (20) @(posedge CLK);
        #1;
        restart(i == 3);
      end
      fetch_and_check();
    end
    summarize();
  end
endmodule : tb_top
